/* core/mpf_scheduler.sv */
// Four-channel multiplexed multi-pulse scheduler with Avalon-MM settings port.
// Assumes crank position and unlock key arrive synchronous to MCLK_IN.
// Operation
// - Up to five enabled pulses per cycle
// - Pulse outputs locked until valid unlock key
// - Everything counts the single system clock
// - Master enable off blocks all pulses
// - Early and first late need enables
// - Second late needs both late enables
// - Main starts at start angle
// - First early leads start by offset
// - Second early leads start by offset
// - Lengths held as 18-bit wrapping counts
// - First late follows main by gap
// - Second late follows first late by gap
// - Handover angle moves engine to next channel
// - One-cycle strobe at every handover
// - Four separate outputs, one per channel
// - Each channel has independent settings
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns

module mpf_scheduler
  import mpf_pkg::*;
(
  input  wire logic                   MCLK_IN,              // System clock
  input  wire logic                   RST_N_IN,             // Sync reset, active low
  input  wire logic [`MPF_ADDR_W-1:0] AVS_ADDRESS_IN,       // Byte address
  input  wire logic                   AVS_READ_IN,          // Read request
  input  wire logic                   AVS_WRITE_IN,         // Write request
  input  wire logic [31:0]            AVS_WRITEDATA_IN,     // Write data
  input  wire logic [3:0]             AVS_BYTEENABLE_IN,    // Byte lanes
  output logic      [31:0]            AVS_READDATA_OUT,     // Read data
  output logic                        AVS_WAITREQUEST_OUT,  // Stall
  input  wire logic [`MPF_ANG_W-1:0]  CRANK_POS_IN,         // Crank angle tick position
  input  wire logic [`MPF_KEY_W-1:0]  UNLOCK_KEY_IN,        // Supervisor key
  output logic                        HANDOVER_STROBE_OUT,  // One-cycle handover flag
  output logic                        PULSE_OUT_CH1_OUT,    // Channel 1 pulses
  output logic                        PULSE_OUT_CH2_OUT,    // Channel 2 pulses
  output logic                        PULSE_OUT_CH3_OUT,    // Channel 3 pulses
  output logic                        PULSE_OUT_CH4_OUT     // Channel 4 pulses
);

  mpf_cfg_if cfg ();

  logic                  rd_pend_reg, rd_pend_next;
  logic                  rd_cfg_reg, rd_cfg_next;
  logic                  rd_stat_reg, rd_stat_next;
  logic [31:0]           stat_reg, stat_next;
  logic                  in_cfg, in_stat;

  logic [`MPF_ANG_W-1:0] prev_pos_reg;
  logic [1:0]            ch_reg, ch_next;
  logic                  strobe_reg, strobe_next;

  logic [`MPF_LEN_W-1:0] e1_cnt_reg, e1_cnt_next, e2_cnt_reg, e2_cnt_next;
  logic [`MPF_LEN_W-1:0] m_cnt_reg, m_cnt_next;
  logic [1:0]            e1_own_reg, e1_own_next, e2_own_reg, e2_own_next;
  logic [1:0]            m_own_reg, m_own_next, lt_own_reg, lt_own_next;
  mpf_late_t             lt_state_reg, lt_state_next;
  logic [`MPF_GAP_W-1:0] lt_cnt_reg, lt_cnt_next;
  logic                  lt_l1en_reg, lt_l1en_next, lt_l2en_reg, lt_l2en_next;
  logic [`MPF_GAP_W-1:0] lt_gap1_reg, lt_gap1_next, lt_gap2_reg, lt_gap2_next;
  logic [`MPF_LEN_W-1:0] lt_len1_reg, lt_len1_next, lt_len2_reg, lt_len2_next;
  logic [3:0]            pulse_reg, pulse_next;

  logic                  cfg_ok, unlocked, hit_e1, hit_e2, hit_main, hit_ho, m_end;
  logic [3:0]            act;

  mpf_cfg_mem u_mem (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .cfg      (cfg)
  );

  // Bus slave: writes complete at once, reads wait one cycle for registered data
  always_comb begin
    in_cfg        = (AVS_ADDRESS_IN[9:8] == 2'h0) && (AVS_ADDRESS_IN[5:2] < `MPF_WORDS);
    in_stat       = (AVS_ADDRESS_IN == `MPF_STATUS_ADDR);
    cfg.wr_en     = AVS_WRITE_IN && in_cfg;
    cfg.rd_en     = AVS_READ_IN && !rd_pend_reg && in_cfg;
    cfg.addr      = AVS_ADDRESS_IN[7:2];
    cfg.wdata     = AVS_WRITEDATA_IN;
    cfg.be        = AVS_BYTEENABLE_IN;
    rd_pend_next  = AVS_READ_IN && !rd_pend_reg;
    rd_cfg_next   = rd_pend_next ? in_cfg : rd_cfg_reg;
    rd_stat_next  = rd_pend_next ? in_stat : rd_stat_reg;
    stat_next     = stat_reg;
    if (rd_pend_next) begin
      stat_next = 32'h0000_0000;
      stat_next[`MPF_ST_PULSE_LSB +: 4] = pulse_reg;
      stat_next[`MPF_ST_CH_LSB +: 2]    = ch_reg;
      stat_next[`MPF_ST_UNLOCK]         = unlocked;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      rd_pend_reg <= 1'b0;
      rd_cfg_reg  <= 1'b0;
      rd_stat_reg <= 1'b0;
      stat_reg    <= 32'h0000_0000;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rd_cfg_reg  <= rd_cfg_next;
      rd_stat_reg <= rd_stat_next;
      stat_reg    <= stat_next;
    end
  end

  assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rd_pend_reg;
  assign AVS_READDATA_OUT    = rd_cfg_reg ? cfg.rdata : (rd_stat_reg ? stat_reg : 32'h0000_0000);

  assign cfg.view_sel = ch_reg;
  assign cfg_ok       = (cfg.view_ch == ch_reg);
  assign unlocked     = (UNLOCK_KEY_IN == `MPF_UNLOCK_KEY);

  always_comb begin
    hit_main = cfg_ok && cfg.view.master
               && mpf_angle_hit(CRANK_POS_IN, prev_pos_reg, cfg.view.start);
    hit_e1   = cfg_ok && cfg.view.master && cfg.view.en_e1
               && mpf_angle_hit(CRANK_POS_IN, prev_pos_reg, cfg.view.start - cfg.view.lead1);
    hit_e2   = cfg_ok && cfg.view.master && cfg.view.en_e2
               && mpf_angle_hit(CRANK_POS_IN, prev_pos_reg, cfg.view.start - cfg.view.lead2);
    hit_ho   = cfg_ok && mpf_angle_hit(CRANK_POS_IN, prev_pos_reg, cfg.view.handover);
    m_end    = (m_cnt_reg == 18'h00001);
    ch_next     = hit_ho ? ch_reg + 2'h1 : ch_reg;
    strobe_next = hit_ho;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      prev_pos_reg <= '0;
      ch_reg       <= 2'h0;
      strobe_reg   <= 1'b0;
    end else begin
      prev_pos_reg <= CRANK_POS_IN;
      ch_reg       <= ch_next;
      strobe_reg   <= strobe_next;
    end
  end

  // Pulse generators each own a channel until done, so a handover does not cut them
  // four pulse generators; the late sequencer makes both late pulses
  always_comb begin
    e1_cnt_next   = (e1_cnt_reg != '0) ? e1_cnt_reg - 18'h00001 : e1_cnt_reg;
    e2_cnt_next   = (e2_cnt_reg != '0) ? e2_cnt_reg - 18'h00001 : e2_cnt_reg;
    m_cnt_next    = (m_cnt_reg != '0) ? m_cnt_reg - 18'h00001 : m_cnt_reg;
    e1_own_next   = e1_own_reg;
    e2_own_next   = e2_own_reg;
    m_own_next    = m_own_reg;
    lt_own_next   = lt_own_reg;
    lt_l1en_next  = lt_l1en_reg;
    lt_l2en_next  = lt_l2en_reg;
    lt_gap1_next  = lt_gap1_reg;
    lt_gap2_next  = lt_gap2_reg;
    lt_len1_next  = lt_len1_reg;
    lt_len2_next  = lt_len2_reg;
    lt_state_next = lt_state_reg;
    lt_cnt_next   = (lt_cnt_reg != '0) ? lt_cnt_reg - 24'h000001 : lt_cnt_reg;
    if (hit_e1) begin
      e1_cnt_next = cfg.view.len_e1;
      e1_own_next = ch_reg;
    end
    if (hit_e2) begin
      e2_cnt_next = cfg.view.len_e2;
      e2_own_next = ch_reg;
    end
    if (hit_main) begin
      m_cnt_next   = cfg.view.len_main;
      m_own_next   = ch_reg;
      lt_l1en_next = cfg.view.en_l1;
      lt_l2en_next = cfg.view.en_l1 && cfg.view.en_l2;
      lt_gap1_next = cfg.view.gap1;
      lt_gap2_next = cfg.view.gap2;
      lt_len1_next = cfg.view.len_l1;
      lt_len2_next = cfg.view.len_l2;
    end
    unique case (lt_state_reg)
      LT_IDLE: begin
        if (m_end && lt_l1en_reg) begin
          lt_own_next   = m_own_reg;
          lt_state_next = (lt_gap1_reg == '0) ? LT_ON1 : LT_GAP1;
          lt_cnt_next   = (lt_gap1_reg == '0) ? {6'h00, lt_len1_reg} : lt_gap1_reg;
        end
      end
      LT_GAP1: begin
        if (lt_cnt_reg <= 24'h000001) begin
          lt_state_next = LT_ON1;
          lt_cnt_next   = {6'h00, lt_len1_reg};
        end
      end
      LT_ON1: begin
        if (lt_cnt_reg <= 24'h000001) begin
          if (!lt_l2en_reg) begin
            lt_state_next = LT_IDLE;
          end else begin
            lt_state_next = (lt_gap2_reg == '0) ? LT_ON2 : LT_GAP2;
            lt_cnt_next   = (lt_gap2_reg == '0) ? {6'h00, lt_len2_reg} : lt_gap2_reg;
          end
        end
      end
      LT_GAP2: begin
        if (lt_cnt_reg <= 24'h000001) begin
          lt_state_next = LT_ON2;
          lt_cnt_next   = {6'h00, lt_len2_reg};
        end
      end
      LT_ON2: begin
        if (lt_cnt_reg <= 24'h000001) begin
          lt_state_next = LT_IDLE;
        end
      end
    endcase
    for (int c = 0; c < 4; c++) begin
      act[c] = ((e1_cnt_reg != '0) && (e1_own_reg == 2'(c)))
            || ((e2_cnt_reg != '0) && (e2_own_reg == 2'(c)))
            || ((m_cnt_reg != '0) && (m_own_reg == 2'(c)))
            || ((lt_state_reg == LT_ON1 || lt_state_reg == LT_ON2)
                && (lt_cnt_reg != '0) && (lt_own_reg == 2'(c)));
    end
    pulse_next = unlocked ? act : 4'h0;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      e1_cnt_reg   <= '0;
      e2_cnt_reg   <= '0;
      m_cnt_reg    <= '0;
      e1_own_reg   <= 2'h0;
      e2_own_reg   <= 2'h0;
      m_own_reg    <= 2'h0;
      lt_own_reg   <= 2'h0;
      lt_state_reg <= LT_IDLE;
      lt_cnt_reg   <= '0;
      lt_l1en_reg  <= 1'b0;
      lt_l2en_reg  <= 1'b0;
      lt_gap1_reg  <= '0;
      lt_gap2_reg  <= '0;
      lt_len1_reg  <= '0;
      lt_len2_reg  <= '0;
      pulse_reg    <= 4'h0;
    end else begin
      e1_cnt_reg   <= e1_cnt_next;
      e2_cnt_reg   <= e2_cnt_next;
      m_cnt_reg    <= m_cnt_next;
      e1_own_reg   <= e1_own_next;
      e2_own_reg   <= e2_own_next;
      m_own_reg    <= m_own_next;
      lt_own_reg   <= lt_own_next;
      lt_state_reg <= lt_state_next;
      lt_cnt_reg   <= lt_cnt_next;
      lt_l1en_reg  <= lt_l1en_next;
      lt_l2en_reg  <= lt_l2en_next;
      lt_gap1_reg  <= lt_gap1_next;
      lt_gap2_reg  <= lt_gap2_next;
      lt_len1_reg  <= lt_len1_next;
      lt_len2_reg  <= lt_len2_next;
      pulse_reg    <= pulse_next;
    end
  end

  assign HANDOVER_STROBE_OUT = strobe_reg;
  assign PULSE_OUT_CH1_OUT   = pulse_reg[0];
  assign PULSE_OUT_CH2_OUT   = pulse_reg[1];
  assign PULSE_OUT_CH3_OUT   = pulse_reg[2];
  assign PULSE_OUT_CH4_OUT   = pulse_reg[3];

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_main_ends_late;
    m_end && lt_l1en_reg && lt_state_reg == LT_IDLE && lt_gap1_reg != '0;
  endsequence
  sequence s_gap_loaded;
    lt_state_reg == LT_GAP1 && lt_cnt_reg == $past(lt_gap1_reg);
  endsequence

  a_lock_forces_low: assert property (!unlocked |=> pulse_reg == 4'h0)
    else $error("output active while locked");
  a_idle_output_low: assert property (act == 4'h0 |=> pulse_reg == 4'h0)
    else $error("output active with no pulse running");
  a_strobe_one_cycle: assert property (strobe_reg |=> !strobe_reg)
    else $error("handover flag longer than one cycle");
  a_handover_steps_ch: assert property (hit_ho |=> strobe_reg && ch_reg == $past(ch_reg) + 2'h1)
    else $error("channel did not advance at handover");
  a_main_load_len: assert property (hit_main |=> m_cnt_reg == $past(cfg.view.len_main))
    else $error("main length not loaded at start");
  a_master_blocks_all: assert property (!cfg.view.master |-> !hit_main && !hit_e1 && !hit_e2)
    else $error("pulse started with master enable off");
  a_early_needs_en: assert property (hit_e1 |-> cfg.view.master && cfg.view.en_e1)
    else $error("first early pulse started while disabled");
  a_second_late_gate: assert property ($rose(lt_state_reg == LT_ON2) |-> lt_l1en_reg && lt_l2en_reg)
    else $error("second late pulse without both enables");
  a_late_gap_start: assert property (s_main_ends_late |=> s_gap_loaded)
    else $error("gap after main not started");
  a_count_per_clock: assert property (m_cnt_reg > 18'h00001 && !hit_main
                                      |=> m_cnt_reg == $past(m_cnt_reg) - 18'h00001)
    else $error("main count skipped a clock");
  a_keep_owner: assert property (m_cnt_reg != '0 && !hit_main |=> m_own_reg == $past(m_own_reg))
    else $error("running main pulse changed channel");

endmodule // mpf_scheduler

/* core/mpf_consts.svh */
// Constants of the four-channel multi-pulse scheduler: widths, offsets, fields, resets.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef MPF_CONSTS_SVH
`define MPF_CONSTS_SVH

`define MPF_CLK_MHZ      40
`define MPF_CHANNELS     4
`define MPF_ANG_W        16
`define MPF_LEN_W        18
`define MPF_GAP_W        24
`define MPF_KEY_W        32
// Arbitrary unlock key value
`define MPF_UNLOCK_KEY   32'h5A3C_96E1

`define MPF_ADDR_W       10
`define MPF_STATUS_ADDR  10'h100
`define MPF_WORDS        4'hC

`define MPF_W_CTRL       4'h0
`define MPF_W_START      4'h1
`define MPF_W_LEAD1      4'h2
`define MPF_W_LEAD2      4'h3
`define MPF_W_LEN_E1     4'h4
`define MPF_W_LEN_E2     4'h5
`define MPF_W_LEN_MAIN   4'h6
`define MPF_W_GAP1       4'h7
`define MPF_W_LEN_L1     4'h8
`define MPF_W_GAP2       4'h9
`define MPF_W_LEN_L2     4'hA
`define MPF_W_HANDOVER   4'hB

`define MPF_B_MASTER     0
`define MPF_B_EN_E1      1
`define MPF_B_EN_E2      2
`define MPF_B_EN_L1      3
`define MPF_B_EN_L2      4
`define MPF_CTRL_MASK    32'h0000_001F

`define MPF_CFG_RST      32'h0000_0000
`define MPF_ST_PULSE_LSB 0
`define MPF_ST_CH_LSB    4
`define MPF_ST_UNLOCK    8

`endif

/* core/mpf_pkg.sv */
// Types and shared helpers of the multi-pulse scheduler.
// Assumes mpf_consts.svh is on the include path.
`include "mpf_consts.svh"

package mpf_pkg;

  typedef struct packed {
    logic                    master;
    logic                    en_e1;
    logic                    en_e2;
    logic                    en_l1;
    logic                    en_l2;
    logic [`MPF_ANG_W-1:0]   start;
    logic [`MPF_ANG_W-1:0]   lead1;
    logic [`MPF_ANG_W-1:0]   lead2;
    logic [`MPF_LEN_W-1:0]   len_e1;
    logic [`MPF_LEN_W-1:0]   len_e2;
    logic [`MPF_LEN_W-1:0]   len_main;
    logic [`MPF_GAP_W-1:0]   gap1;
    logic [`MPF_LEN_W-1:0]   len_l1;
    logic [`MPF_GAP_W-1:0]   gap2;
    logic [`MPF_LEN_W-1:0]   len_l2;
    logic [`MPF_ANG_W-1:0]   handover;
  } mpf_cfg_t;

  typedef enum logic [2:0] {LT_IDLE, LT_GAP1, LT_ON1, LT_GAP2, LT_ON2} mpf_late_t;

  // Bits kept by each configuration word; the rest wrap away
  function automatic logic [31:0] mpf_word_mask(input logic [3:0] idx);
    case (idx)
      `MPF_W_CTRL:                          mpf_word_mask = `MPF_CTRL_MASK;
      `MPF_W_START, `MPF_W_LEAD1, `MPF_W_LEAD2,
      `MPF_W_HANDOVER:                      mpf_word_mask = 32'h0000_FFFF;
      `MPF_W_GAP1, `MPF_W_GAP2:             mpf_word_mask = 32'h00FF_FFFF;
      `MPF_W_LEN_E1, `MPF_W_LEN_E2, `MPF_W_LEN_MAIN,
      `MPF_W_LEN_L1, `MPF_W_LEN_L2:         mpf_word_mask = 32'h0003_FFFF;
      default:                              mpf_word_mask = 32'h0000_0000;
    endcase
  endfunction

  // Crank position has just arrived at the target
  function automatic logic mpf_angle_hit(input logic [`MPF_ANG_W-1:0] pos,
                                         input logic [`MPF_ANG_W-1:0] prev,
                                         input logic [`MPF_ANG_W-1:0] tgt);
    mpf_angle_hit = (pos == tgt) && (prev != tgt);
  endfunction

endpackage

/* core/mpf_cfg_if.sv */
// Carrier between the scheduler and its configuration memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface mpf_cfg_if;
  import mpf_pkg::*;
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic [1:0]  view_sel;
  mpf_cfg_t    view;
  logic [1:0]  view_ch;

  modport mem (input wr_en, rd_en, addr, wdata, be, view_sel,
               output rdata, view, view_ch);
  modport ctl (output wr_en, rd_en, addr, wdata, be, view_sel,
               input rdata, view, view_ch);
endinterface

/* core/mpf_cfg_mem.sv */
// Per-channel settings memory: bus port plus a registered view of one channel.
// Assumes synchronous active-low reset and one clock.
`timescale 1ns/1ns

module mpf_cfg_mem
  import mpf_pkg::*;
(
  input  wire logic clk_in,      // System clock
  input  wire logic rst_n_in,    // Synchronous reset, active low
  mpf_cfg_if.mem    cfg          // Settings port
);

  logic [31:0] mem_reg [0:63];
  logic [31:0] mem_next [0:63];
  logic [31:0] rdata_reg, rdata_next;
  mpf_cfg_t    view_reg, view_next;
  logic [1:0]  view_ch_reg;
  logic [31:0] be_mask;
  logic [31:0] vw [0:11];

  function automatic logic [31:0] word_at(input logic [1:0] ch, input logic [3:0] idx);
    word_at = mem_reg[{ch, idx}];
  endfunction

  always_comb begin
    be_mask = {{8{cfg.be[3]}}, {8{cfg.be[2]}}, {8{cfg.be[1]}}, {8{cfg.be[0]}}};
    for (int i = 0; i < 64; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (cfg.wr_en) begin
      mem_next[cfg.addr] = ((mem_reg[cfg.addr] & ~be_mask) | (cfg.wdata & be_mask))
                           & mpf_word_mask(cfg.addr[3:0]);
    end
    rdata_next = cfg.rd_en ? mem_reg[cfg.addr] : rdata_reg;
    for (int i = 0; i < 12; i++) begin
      vw[i] = word_at(cfg.view_sel, 4'(i));
    end
    view_next.master   = vw[`MPF_W_CTRL][`MPF_B_MASTER];
    view_next.en_e1    = vw[`MPF_W_CTRL][`MPF_B_EN_E1];
    view_next.en_e2    = vw[`MPF_W_CTRL][`MPF_B_EN_E2];
    view_next.en_l1    = vw[`MPF_W_CTRL][`MPF_B_EN_L1];
    view_next.en_l2    = vw[`MPF_W_CTRL][`MPF_B_EN_L2];
    view_next.start    = vw[`MPF_W_START][`MPF_ANG_W-1:0];
    view_next.lead1    = vw[`MPF_W_LEAD1][`MPF_ANG_W-1:0];
    view_next.lead2    = vw[`MPF_W_LEAD2][`MPF_ANG_W-1:0];
    view_next.len_e1   = vw[`MPF_W_LEN_E1][`MPF_LEN_W-1:0];
    view_next.len_e2   = vw[`MPF_W_LEN_E2][`MPF_LEN_W-1:0];
    view_next.len_main = vw[`MPF_W_LEN_MAIN][`MPF_LEN_W-1:0];
    view_next.gap1     = vw[`MPF_W_GAP1][`MPF_GAP_W-1:0];
    view_next.len_l1   = vw[`MPF_W_LEN_L1][`MPF_LEN_W-1:0];
    view_next.gap2     = vw[`MPF_W_GAP2][`MPF_GAP_W-1:0];
    view_next.len_l2   = vw[`MPF_W_LEN_L2][`MPF_LEN_W-1:0];
    view_next.handover = vw[`MPF_W_HANDOVER][`MPF_ANG_W-1:0];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 64; i++) begin
        mem_reg[i] <= `MPF_CFG_RST;
      end
      rdata_reg   <= 32'h0000_0000;
      view_reg    <= '0;
      view_ch_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 64; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rdata_reg   <= rdata_next;
      view_reg    <= view_next;
      view_ch_reg <= cfg.view_sel;
    end
  end

  assign cfg.rdata   = rdata_reg;
  assign cfg.view    = view_reg;
  assign cfg.view_ch = view_ch_reg;

  a_len_wrap_18: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg.wr_en && cfg.addr[3:0] == `MPF_W_LEN_MAIN) |=> (mem_reg[$past(cfg.addr)][31:18] == 14'h0))
    else $error("length word kept bits above 18");

endmodule // mpf_cfg_mem

/* verification/mpf_driver_model.sv */
// Injector-driver side model: counts each channel's pulses and times the last one.
// Assumes pulse inputs are registered outputs on the same clock.
`timescale 1ns/1ns

module mpf_driver_model (
  input  wire logic             clk_in,     // System clock
  input  wire logic             rst_n_in,   // Sync reset, active low
  input  wire logic [3:0]       pulse_in,   // Channel pulse levels
  output logic      [3:0][7:0]  count_out,  // Pulses seen per channel
  output logic      [3:0][15:0] width_out   // Last pulse width in clocks
);
  logic [3:0][15:0] run_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_reg   <= '0;
      count_out <= '0;
      width_out <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (pulse_in[c]) begin
          run_reg[c] <= run_reg[c] + 16'h1;
        end else if (run_reg[c] != 16'h0) begin
          width_out[c] <= run_reg[c];
          count_out[c] <= count_out[c] + 8'h1;
          run_reg[c]   <= 16'h0;
        end
      end
    end
  end
endmodule // mpf_driver_model

/* verification/mpf_scheduler_tb.sv */
// Self-checking bench of the multi-pulse scheduler: register bus, crank sweeps.
// Assumes mpf_consts.svh on the include path and a 100 MHz bench clock.
`timescale 1ns/1ns
`include "mpf_consts.svh"

module mpf_scheduler_tb;
  logic              clk, rst_n, rd, wr, wait_r, strobe;
  logic [9:0]        addr;
  logic [31:0]       wdata, rdata, key, key_src, q, rnd;
  logic [15:0]       pos, first;
  wire  [3:0]        p;
  wire  [3:0][7:0]   cnt;
  wire  [3:0][15:0]  wid;
  int                miscompares, checked, strobes;

  mpf_scheduler i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_r),
    .CRANK_POS_IN(pos), .UNLOCK_KEY_IN(key), .HANDOVER_STROBE_OUT(strobe),
    .PULSE_OUT_CH1_OUT(p[0]), .PULSE_OUT_CH2_OUT(p[1]), .PULSE_OUT_CH3_OUT(p[2]),
    .PULSE_OUT_CH4_OUT(p[3]));
  mpf_driver_model i_drv (.clk_in(clk), .rst_n_in(rst_n), .pulse_in(p),
    .count_out(cnt), .width_out(wid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always_ff @(posedge clk) key <= key_src;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  // Output rises two clocks after the crank meets the target: hit, count load, register
  function automatic logic [31:0] rise_at(input logic [15:0] s, input logic [15:0] l);
    rise_at = {16'h0000, s - l + 16'h0002};
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    @(posedge clk);
    while (wait_r !== 1'b0) begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        miscompares++;
        final_report;
      end
    end
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask

  task run(input logic [31:0] ctrl, input logic [31:0] len, input logic [31:0] hand,
           input logic ok);
    logic [31:0] v [12];
    int i;
    v = '{ctrl, 100, 20, 10, 3, 4, len, 2, 5, 3, 6, hand};
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    key_src <= ok ? `MPF_UNLOCK_KEY : 32'h0000_0000;
    for (i = 0; i < 12; i++) bus(1'b1, {4'h0, i[3:0], 2'h0}, v[i]);
    strobes = 0;
    first = 16'hFFFF;
    for (i = 0; i < 240; i++) begin
      @(posedge clk);
      if (strobe === 1'b1) strobes++;
      if (p[0] === 1'b1 && first === 16'hFFFF) first = pos;
      pos <= i[15:0];
    end
    bus(1'b0, 10'h100, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 10'h0; wdata = 32'h0; pos = 16'h0;
    key_src = 32'h0; rnd = 32'h0000_1234; miscompares = 0; checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 10'h100, 32'h0);
    chk("status", 32'h0, q);
    chk("outputs", 32'h0, {strobe, p});
    bus(1'b1, 10'h000, 32'hFFFF_FFFF);
    bus(1'b0, 10'h000, 32'h0);
    chk("ctrl", 32'h1F, q);
    bus(1'b1, 10'h018, 32'hFFFF_FFFF);
    bus(1'b0, 10'h018, 32'h0);
    chk("main length", 32'h3_FFFF, q);
    bus(1'b1, 10'h01C, 32'hFFFF_FFFF);
    bus(1'b0, 10'h01C, 32'h0);
    chk("gap", 32'hFF_FFFF, q);
    bus(1'b1, 10'h070, 32'hFFFF_FFFF);
    bus(1'b0, 10'h070, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    run(32'h1F, 32'h7, 32'd180, 1'b1);
    chk("pulse count", 32'h5, cnt[0]);
    chk("early rise", rise_at(16'h0064, 16'h0014), first);
    chk("strobes", 32'h1, strobes);
    chk("last width", 32'h6, wid[0]);
    chk("active channel", 32'h1, q[5:4]);
    chk("unlocked", 32'h1, q[8]);
    chk("other channels", 32'h0, cnt[3:1]);
    $display("test five pulses done");
    run(32'h1E, 32'h7, 32'd180, 1'b1);
    chk("master off", 32'h0, cnt[0]);
    run(32'h11, 32'h7, 32'd180, 1'b1);
    chk("late2 alone", 32'h1, cnt[0]);
    chk("main rise", rise_at(16'h0064, 16'h0000), first);
    run(32'h05, 32'h7, 32'd180, 1'b1);
    chk("early2 count", 32'h2, cnt[0]);
    chk("early2 rise", rise_at(16'h0064, 16'h000A), first);
    run(32'h1F, 32'h7, 32'd180, 1'b0);
    chk("locked", 32'h0, cnt[0]);
    $display("test enables and lock done");
    for (int n = 0; n < 3; n++) begin
      rnd = xs(rnd);
      run(32'h1, 32'h1 + rnd % 8, 32'd102, 1'b1);
      chk("main width", 32'h1 + rnd % 8, wid[0]);
    end
    $display("test handover mid-pulse done");
    final_report;
  end
endmodule // mpf_scheduler_tb
